//--- twi_defines.svh
// Timing and layout constants for the two-wire bus engine.
// Assumes a 10 MHz core clock; included by the package, whose include also gives the engine its macros.
`ifndef TWI_DEFINES_SVH
`define TWI_DEFINES_SVH
`define TWI_CLK_HZ 10000000
`define TWI_HALF_NS 2500
`define TWI_HALF_CYC ((`TWI_HALF_NS * (`TWI_CLK_HZ / 1000000)) / 1000)
`define TWI_BITS_PER_BYTE 8
`define TWI_ACK_BIT 8
`endif

//--- twi_pkg.sv
// Types shared by the two-wire bus engine.
// Assumes twi_defines.svh is on the include path.
`include "twi_defines.svh"
package twi_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_START = 4'h1,
      ST_LOW = 4'h2,
      ST_HIGH = 4'h3,
      ST_STOP1 = 4'h4,
      ST_STOP2 = 4'h5,
      ST_RSTART = 4'h6,
      ST_SLV = 4'h7
   } twi_state_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic rd;
      logic ack;
      logic [7:0] data;
   } twi_cmd_t;
   typedef struct packed {
      logic done;
      logic nack;
      logic lost;
      logic busy;
      logic [7:0] data;
   } twi_rsp_t;
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      twi_state_t st;
      logic [15:0] cnt;
      logic [3:0] bit_n;
      logic [7:0] sh;
      logic scl_oe;
      logic sda_oe;
      logic own;
      logic rd;
      logic ack;
      logic stop_req;
      logic [1:0] slv_ph;
      logic slv_tx_drv;
      twi_rsp_t rsp;
   } twi_state_reg_t;
endpackage

//--- twi_engine.sv
// Two-wire bus master engine with arbitration, clock stretching and bus watch.
// Assumes open-drain pins resolved outside; pins sampled on the core clock.
`timescale 1ns/1ns
`default_nettype none
module twi_engine
   import twi_pkg::*;
#(
   parameter int HALF_CYC = `TWI_HALF_CYC
)(
   input wire logic ref_clk_i,        // Core clock, 10 MHz.
   input wire logic rst_i,            // Asynchronous reset, active high.
   input wire logic scl_i,            // SCL level on the bus.
   output logic scl_o,                // SCL drive level, always low.
   output logic scl_oe_o,             // SCL pulled low while high.
   input wire logic sda_i,            // SDA level on the bus.
   output logic sda_o,                // SDA drive level, always low.
   output logic sda_oe_o,             // SDA pulled low while high.
   input wire logic cmd_valid_i,      // Byte command offered.
   input wire twi_cmd_t cmd_i,        // Byte command.
   output logic cmd_ready_o,          // Command taken this cycle, except in idle without start set or with SCL or SDA low.
   output twi_rsp_t rsp_o,            // Result of the last byte.
   output logic start_seen_o,         // Start seen on the bus, one pulse.
   output logic stop_seen_o           // Stop seen on the bus, one pulse.
);
   if (HALF_CYC < 2 || HALF_CYC > 65535)
   begin : g_chk
      $error("HALF_CYC out of range");
   end
   twi_state_reg_t q, d;
   logic scl_v, sda_v, scl_rise, scl_fall, start_ev, stop_ev;
   always_comb
   begin
      scl_v = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[1] : q.scl_f;
      sda_v = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[1] : q.sda_f;
      scl_rise = scl_v && !q.scl_f;
      scl_fall = !scl_v && q.scl_f;
      start_ev = q.scl_f && scl_v && q.sda_f && !sda_v;
      stop_ev = q.scl_f && scl_v && !q.sda_f && sda_v;
   end
   assign cmd_ready_o = cmd_valid_i && !q.rsp.busy &&
      (q.st == ST_IDLE || (q.st == ST_LOW && q.own && q.bit_n == 4'h0 && q.cnt == 16'h0));
   always_comb
   begin
      d = q;
      d.scl_s = {q.scl_s[1:0], scl_i};
      d.sda_s = {q.sda_s[1:0], sda_i};
      d.scl_f = scl_v;
      d.sda_f = sda_v;
      d.rsp.done = 1'b0;
      if (q.cnt != 16'h0)
         d.cnt = q.cnt - 16'h1;
      unique case (q.st)
         ST_IDLE, ST_SLV:
         begin
            if (stop_ev)
            begin
               d.st = ST_IDLE;
               d.sda_oe = 1'b0;
               d.slv_tx_drv = 1'b0;
            end
            if (cmd_ready_o && cmd_i.start && scl_v && sda_v)
            begin
               d.st = ST_START;
               d.sda_oe = 1'b1;
               d.cnt = 16'(HALF_CYC);
               d.sh = cmd_i.data;
               d.rd = 1'b0;
               d.ack = cmd_i.ack;
               d.stop_req = cmd_i.stop;
               d.rsp.busy = 1'b1;
               d.rsp.nack = 1'b0;
               d.rsp.lost = 1'b0;
            end
            else if (q.st == ST_SLV && scl_fall && q.sda_oe && q.slv_ph == 2'h1)
               d.sda_oe = 1'b0;
         end
         ST_START:
            if (q.cnt == 16'h0)
            begin
               d.scl_oe = 1'b1;
               d.own = 1'b1;
               d.st = ST_LOW;
               d.bit_n = 4'h0;
               d.cnt = 16'(HALF_CYC);
            end
         ST_RSTART:
            if (q.cnt == 16'h0)
            begin
               if (!q.scl_oe && scl_v)
               begin
                  d.sda_oe = 1'b1;
                  d.st = ST_START;
                  d.cnt = 16'(HALF_CYC);
               end
               else
               begin
                  d.sda_oe = 1'b0;
                  d.scl_oe = 1'b0;
                  d.cnt = 16'(HALF_CYC);
               end
            end
         ST_LOW:
         begin
            if (q.bit_n == 4'h0 && q.cnt == 16'h0 && q.rsp.busy == 1'b0)
            begin
               if (cmd_ready_o)
               begin
                  d.sh = cmd_i.data;
                  d.rd = cmd_i.rd;
                  d.ack = cmd_i.ack;
                  d.stop_req = cmd_i.stop;
                  d.rsp.busy = 1'b1;
                  d.rsp.nack = 1'b0;
                  d.cnt = 16'(HALF_CYC);
                  if (cmd_i.start)
                  begin
                     d.st = ST_RSTART;
                     d.sda_oe = 1'b0;
                     d.cnt = 16'(HALF_CYC);
                  end
               end
            end
            else if (q.cnt == 16'(HALF_CYC / 2) && q.rsp.busy)
            begin
               if (q.bit_n == 4'(`TWI_ACK_BIT))
                  d.sda_oe = q.rd && q.ack;
               else
                  d.sda_oe = !q.rd && !q.sh[7];
            end
            else if (q.cnt == 16'h0)
            begin
               d.scl_oe = 1'b0;
               d.st = ST_HIGH;
            end
         end
         ST_HIGH:
            // A zero count with SCL low means the line is still held low by someone else.
            if (scl_rise)
               d.cnt = 16'(HALF_CYC);
            else if ((scl_v && q.cnt == 16'h0) || (!scl_v && q.cnt != 16'h0))
            begin
               d.scl_oe = 1'b1;
               d.st = ST_LOW;
               d.cnt = 16'(HALF_CYC);
               d.bit_n = q.bit_n + 4'h1;
               if (q.bit_n == 4'(`TWI_ACK_BIT))
               begin
                  d.bit_n = 4'h0;
                  d.rsp.busy = 1'b0;
                  d.rsp.done = 1'b1;
                  d.rsp.data = q.sh;
                  d.rsp.nack = q.rd ? 1'b0 : sda_v;
                  if (q.stop_req || (!q.rd && sda_v))
                     d.st = ST_STOP1;
               end
               else
                  d.sh = {q.sh[6:0], q.rd ? sda_v : q.sh[7]};
            end
            else if (q.bit_n != 4'(`TWI_ACK_BIT) && !q.rd && q.sda_oe == 1'b0 &&
                     !sda_v && scl_v)
            begin
               d.st = ST_SLV;
               d.own = 1'b0;
               d.scl_oe = 1'b0;
               d.sda_oe = 1'b0;
               d.rsp.lost = 1'b1;
               d.rsp.busy = 1'b0;
               d.rsp.done = 1'b1;
               d.slv_ph = 2'h0;
            end
         ST_STOP1:
            if (q.cnt == 16'(HALF_CYC / 2))
               d.sda_oe = 1'b1;
            else if (q.cnt == 16'h0)
            begin
               d.scl_oe = 1'b0;
               d.st = ST_STOP2;
               d.cnt = 16'(HALF_CYC);
            end
         ST_STOP2:
            if (q.cnt == 16'h0 && scl_v)
            begin
               d.sda_oe = 1'b0;
               d.own = 1'b0;
               d.st = ST_IDLE;
            end
         default:
            d.st = ST_IDLE;
      endcase
      if (q.st == ST_SLV && q.slv_tx_drv && scl_fall)
         d.sda_oe = 1'b0;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.scl_f <= 1'b1;
         q.sda_f <= 1'b1;
      end
      else
         q <= d;
   end
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = q.scl_oe;
   assign sda_oe_o = q.sda_oe;
   assign rsp_o = q.rsp;
   assign start_seen_o = start_ev;
   assign stop_seen_o = stop_ev;

   a_sda_stable_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == ST_HIGH && $stable(q.st)) |-> $stable(q.sda_oe))
      else $error("SDA drive changed while clock released");
   a_lost_releases: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(q.st) == ST_HIGH && q.st == ST_SLV) |-> (!q.sda_oe && !q.own && q.rsp.lost))
      else $error("Losing master kept driving SDA");
   a_lost_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(q.rsp.lost) |-> (q.st == ST_SLV && !q.sda_oe && !q.scl_oe))
      else $error("Lost arbitration without release");
   a_stop_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(q.st) == ST_STOP2 && q.st == ST_IDLE) |-> (!q.sda_oe && scl_v))
      else $error("Stop released SDA with SCL low");
   a_nack_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.rsp.done && q.rsp.nack) |-> (q.st == ST_STOP1))
      else $error("Missing acknowledge not followed by stop");
   a_start_pat: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(q.st) == ST_IDLE && q.st == ST_START) |-> (q.sda_oe && !q.scl_oe))
      else $error("Start not driven with SCL released");
   a_byte_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      q.bit_n <= 4'(`TWI_ACK_BIT))
      else $error("Bit counter beyond ninth clock");
   a_sda_in_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($changed(q.sda_oe) && q.own && $past(q.st) inside {ST_LOW, ST_HIGH}) |->
      $past(q.scl_oe))
      else $error("SDA moved outside low phase");
endmodule
`default_nettype wire

//--- twi_slave_model.sv
// Behavioural slave on the far side of the two-wire bus, with optional clock stretching.
// Assumes pulled-up bus levels on scl_i and sda_i; an oe output high pulls its line low.
`timescale 1ns/1ns
`default_nettype none
module twi_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a
)(
   input wire logic scl_i,           // SCL bus level.
   input wire logic sda_i,           // SDA bus level.
   input wire logic nack_i,          // Decline data bytes.
   input wire logic stretch_i,       // Hold each SCL low phase longer.
   input wire logic [7:0] tx_byte_i, // Byte returned on reads.
   output logic sda_oe_o,            // Pulls SDA low.
   output logic scl_oe_o,            // Pulls SCL low.
   output logic [7:0] rx_byte_o      // Last byte taken in.
);
   logic act = 0;
   logic first = 0;
   logic tx = 0;
   logic [3:0] bit_n = 0;
   logic [7:0] sh = 0;
   initial
   begin
      sda_oe_o = 0;
      scl_oe_o = 0;
      rx_byte_o = 0;
   end
   always @(negedge sda_i)
      if (scl_i)
      begin
         act = 1;
         first = 1;
         bit_n = 0;
         tx = 0;
      end
   always @(posedge sda_i)
      if (scl_i)
      begin
         act = 0;
         tx = 0;
         sda_oe_o <= 0;
      end
   always @(posedge scl_i)
      if (act)
      begin
         if (bit_n < 8)
            sh = {sh[6:0], sda_i};
         else if (tx && sda_i)
            tx = 0;
         bit_n = bit_n + 1;
      end
   // Data moves 200 ns after SCL falls, so it never changes around the high phase.
   always @(negedge scl_i)
      if (act)
      begin
         if (stretch_i)
         begin
            scl_oe_o = 1;
            scl_oe_o <= #1500 0;
         end
         if (bit_n == 9)
         begin
            if (first)
               tx = (sh == {ADDR, 1'b1});
            first = 0;
            bit_n = 0;
            if (tx)
               sh = tx_byte_i;
         end
         if (bit_n == 8 && !tx)
         begin
            rx_byte_o = sh;
            sda_oe_o <= #200 first ? (sh[7:1] == ADDR) : !nack_i;
         end
         else
            sda_oe_o <= #200 tx && bit_n < 8 && !sh[7];
      end
endmodule
`default_nettype wire

//--- tb_two_wire_bus_transfer_arbitration.sv
// Self-checking bench for the two-wire bus engine against a behavioural far-side slave.
// Assumes twi_pkg, twi_engine and twi_slave_model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_two_wire_bus_transfer_arbitration
   import twi_pkg::*;
;
   localparam logic [6:0] SLV = 7'h2a;
   logic ref_clk_i = 0;
   logic rst_i = 1;
   logic cmd_valid_i = 0;
   twi_cmd_t cmd_i = '0;
   logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, cmd_ready, start_seen, stop_seen;
   logic arb_oe = 0, nack = 0, stretch = 0;
   logic [7:0] rx_byte;
   twi_rsp_t rsp;
   int failures = 0, samples_checked = 0, n_start = 0, n_stop = 0, n_pulse = 0;
   int np, s0, b0, n;
   time t_fall = 0, t_low = 0;
   wire scl = ~(scl_oe | m_scl_oe);
   wire sda = ~(sda_oe | m_sda_oe | arb_oe);
   always #50 ref_clk_i = ~ref_clk_i;
   always @(negedge scl) t_fall = $time;
   always @(posedge scl)
   begin
      n_pulse++;
      t_low = $time - t_fall;
   end
   always @(posedge ref_clk_i)
   begin
      n_start += start_seen;
      n_stop += stop_seen;
   end
   twi_engine #(.HALF_CYC(4)) i_twi_engine (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready), .rsp_o(rsp),
      .start_seen_o(start_seen), .stop_seen_o(stop_seen));
   twi_slave_model #(.ADDR(SLV)) i_twi_slave_model (.scl_i(scl), .sda_i(sda),
      .nack_i(nack), .stretch_i(stretch), .tx_byte_i(8'h96), .sda_oe_o(m_sda_oe),
      .scl_oe_o(m_scl_oe), .rx_byte_o(rx_byte));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic step(inout int k, input int lim);
      @(negedge ref_clk_i);
      k++;
      if (k > lim)
      begin
         chk(0, 1);
         end_sim;
      end
   endtask
   task automatic issue(input twi_cmd_t c);
      int k;
      k = 0;
      @(negedge ref_clk_i);
      cmd_valid_i = 1;
      cmd_i = c;
      @(posedge ref_clk_i);
      while (cmd_ready !== 1'b1)
      begin
         step(k, 500);
         @(posedge ref_clk_i);
      end
      @(negedge ref_clk_i);
      cmd_valid_i = 0;
      np = n_pulse;
   endtask
   task automatic xfer(input logic s, p, r, a, input logic [7:0] d);
      int k;
      k = 0;
      issue('{s, p, r, a, d});
      while (rsp.done !== 1'b1) step(k, 3000);
   endtask
   task automatic wait_stop;
      int k;
      k = 0;
      while (n_stop == s0) step(k, 500);
   endtask
   task automatic t_write;
      s0 = n_stop;
      xfer(1, 0, 0, 1, {SLV, 1'b0});
      chk(rsp.nack, 0);
      chk(rsp.busy, 0);
      xfer(0, 1, 0, 1, 8'ha5);
      chk(n_pulse - np, 9);
      chk(rsp.nack, 0);
      chk(rx_byte, 8'ha5);
      wait_stop;
      chk({scl, sda}, 2'b11);
      $display("test write done");
   endtask
   task automatic t_nack;
      s0 = n_stop;
      xfer(1, 0, 0, 1, {SLV, 1'b0});
      nack = 1;
      xfer(0, 0, 0, 1, 8'h3c);
      chk(rsp.nack, 1);
      wait_stop;
      chk(n_stop - s0, 1);
      nack = 0;
      $display("test nack done");
   endtask
   task automatic t_read;
      s0 = n_stop;
      b0 = n_start;
      xfer(1, 0, 0, 1, {SLV, 1'b0});
      xfer(0, 0, 0, 1, 8'h10);
      chk(rx_byte, 8'h10);
      xfer(1, 0, 0, 1, {SLV, 1'b1});
      chk(n_start - b0, 2);
      chk(n_stop - s0, 0);
      xfer(0, 1, 1, 0, 8'h00);
      chk(rsp.data, 8'h96);
      chk(i_twi_slave_model.tx, 0);
      wait_stop;
      chk(m_sda_oe, 0);
      $display("test read done");
   endtask
   task automatic t_stretch;
      s0 = n_stop;
      stretch = 1;
      xfer(1, 0, 0, 1, {SLV, 1'b0});
      xfer(0, 1, 0, 1, 8'h5a);
      stretch = 0;
      chk(t_low >= 1500, 1);
      chk(rx_byte, 8'h5a);
      wait_stop;
      $display("test stretch done");
   endtask
   task automatic t_arb;
      s0 = n_stop;
      n = 0;
      issue('{1'b1, 1'b0, 1'b0, 1'b1, 8'h80});
      while (scl !== 1'b0) step(n, 500);
      arb_oe = 1;
      while (rsp.lost !== 1'b1) step(n, 500);
      chk(rsp.lost, 1);
      chk(sda_oe, 0);
      repeat (20) @(negedge ref_clk_i);
      chk(sda_oe, 0);
      chk(scl_oe, 0);
      while (scl !== 1'b1) step(n, 1000);
      arb_oe = 0;
      wait_stop;
      $display("test arbitration done");
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_i = 0;
      repeat (5) @(negedge ref_clk_i);
      t_write;
      t_nack;
      t_read;
      t_stretch;
      t_arb;
      t_write;
      end_sim;
   end
endmodule
`default_nettype wire
